// *** design/fpk_front_panel.sv ***
//////////////////////////////////////////////////////////////////////////////
// Contract
// - each shift key press toggles it; on flashes LED, off darkens it (design: outside self test, number pressed with set-up, both off, stays off)
// - both shift keys never on together, except self-test phases (design: both stay on one cycle after self test ends)
// - normal mode two-state key cycles upper, lower, off
// - key LEDs show activity; multi-state key lights only current LED
// - stepping keys move one list entry per press in their direction
// - held stepping key auto-repeats until release
// - both shifts off: main keys act as face labels (normal)
// - set-up shift on: main keys act as parameter-menu functions
// - number shift on, set-up shift off: main keys act as digit keypad
// - power-up shows exactly one of restored, reset, initialised
// - memory intact: keep everything, show restored
// - settings fault: default settings, keep history, show reset
// - retention exceeded: defaults, erase history and set-ups, initialised
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module fpk_front_panel
  import fpk_pkg::*;
#(
  parameter int unsigned NKEYS       = NUM_MAIN_KEYS,
  parameter int unsigned DEB_CYC     = DEBOUNCE_CYC,
  parameter int unsigned RPT_DLY_CYC = REPEAT_DELAY_CYC,
  parameter int unsigned RPT_CYC     = REPEAT_RATE_CYC,
  parameter int unsigned FLS_CYC     = FLASH_CYC
) (
  input  wire logic              clk_i,           // system clock, 200 MHz
  input  wire logic              rst_i,           // async reset, active high
  input  wire logic              setup_key_i,     // raw set-up shift key
  input  wire logic              number_key_i,    // raw number shift key
  input  wire logic              step_up_key_i,   // raw step-forward key
  input  wire logic              step_dn_key_i,   // raw step-back key
  input  wire logic [NKEYS-1:0]  main_keys_i,     // raw main keys
  input  wire logic              self_test_i,     // self-test phase allows both shifts
  input  wire logic [LIST_W-1:0] list_len_i,      // entries in current list
  input  wire logic              list_load_i,     // reload list position to zero
  input  wire logic              mem_intact_i,    // battery memory survived
  input  wire logic              db_fault_i,      // menu settings check failed
  input  wire logic              pwrup_done_i,    // power-up checks valid
  output logic                   setup_led_o,     // set-up shift LED (flashing)
  output logic                   number_led_o,    // number shift LED (flashing)
  output fpk_mode_e              mode_o,          // current key mode
  output fpk_key_evt_s           key_evt_o,       // decoded main key event
  output logic [MAIN_IDX_W-1:0]  digit_o,         // digit for number mode
  output logic                   ohm_upper_led_o, // ohmic-drop comp LED
  output logic                   ohm_lower_led_o, // polarization resist LED
  output logic [1:0]             ohm_state_o,     // two-state key state
  output logic [LIST_W-1:0]      list_pos_o,      // list position
  output logic                   step_up_o,       // step-forward pulse
  output logic                   step_dn_o,       // step-back pulse
  output fpk_msg_e               msg_o,           // power-up message
  output fpk_pwrup_cmd_s         pwrup_cmd_o      // memory housekeeping
);

  localparam int unsigned NRAW = NKEYS + 4;
  localparam int unsigned FW   = $clog2(FLS_CYC + 1);

  //////////////////////////////////////////////////////////////////////////////
  // debounce

  wire [NRAW-1:0] raw = {main_keys_i, step_dn_key_i, step_up_key_i, number_key_i,
                         setup_key_i};
  logic [NRAW-1:0] lvl;
  logic [NRAW-1:0] prs;

  fpk_debounce #(
    .WIDTH      (NRAW),
    .STABLE_CYC (DEB_CYC)
  ) u_deb (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   (raw),
    .level_o (lvl),
    .press_o (prs)
  );

  wire             setup_prs  = prs[0];
  wire             number_prs = prs[1];
  wire [NKEYS-1:0] main_prs   = prs[NRAW-1:4];

  //////////////////////////////////////////////////////////////////////////////
  // shift keys

  logic setup_on_reg;
  logic number_on_reg;

  // pressing one shift forces the other off outside self test
  wire setup_next  = setup_prs ? !setup_on_reg
                   : (number_prs && !number_on_reg && !self_test_i) ? 1'b0
                   : setup_on_reg;
  wire number_next = number_prs ? !number_on_reg
                   : (setup_prs && !setup_on_reg && !self_test_i) ? 1'b0
                   : number_on_reg;
  // simultaneous presses with both off: set-up wins outside self test
  wire number_adj  = number_next && !(setup_next && !self_test_i);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      setup_on_reg  <= 1'b0;
      number_on_reg <= 1'b0;
    end else begin
      setup_on_reg  <= setup_next;
      number_on_reg <= number_adj;
    end
  end

  // flash divider: one enable pulse per half period
  logic [FW-1:0] fls_cnt_reg;
  logic          fls_reg;
  wire           fls_tick = fls_cnt_reg == FW'(FLS_CYC - 1);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fls_cnt_reg <= '0;
      fls_reg     <= 1'b0;
    end else begin
      fls_cnt_reg <= fls_tick ? '0 : fls_cnt_reg + FW'(1);
      if (fls_tick) fls_reg <= !fls_reg;
    end
  end

  assign setup_led_o  = setup_on_reg && fls_reg;
  assign number_led_o = number_on_reg && fls_reg;

  //////////////////////////////////////////////////////////////////////////////
  // mode and main keys

  wire fpk_mode_e mode_now = setup_on_reg  ? FPK_MODE_SETUP
                           : number_on_reg ? FPK_MODE_NUMBER
                           : FPK_MODE_NORMAL;
  assign mode_o = mode_now;

  function automatic logic [MAIN_IDX_W-1:0] first_idx(input logic [NKEYS-1:0] v);
    logic [MAIN_IDX_W-1:0] r;
    r = '0;
    for (int i = NKEYS - 1; i >= 0; i--) begin
      if (v[i]) r = MAIN_IDX_W'(i);
    end
    return r;
  endfunction : first_idx

  wire                  any_main = |main_prs;
  wire [MAIN_IDX_W-1:0] main_idx = first_idx(main_prs);
  fpk_key_evt_s         evt_reg;
  logic [1:0]           ohm_reg;

  // key 0 is the two-state compensation key in normal mode
  wire ohm_hit = any_main && main_idx == '0 && mode_now == FPK_MODE_NORMAL;
  wire [1:0] ohm_next = (ohm_reg == TWO_STATE_OFF)   ? TWO_STATE_UPPER
                      : (ohm_reg == TWO_STATE_UPPER) ? TWO_STATE_LOWER
                      : TWO_STATE_OFF;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_reg <= '0;
      ohm_reg <= TWO_STATE_OFF;
    end else begin
      evt_reg.valid <= any_main;
      evt_reg.mode  <= mode_now;
      evt_reg.key   <= main_idx;
      if (ohm_hit) ohm_reg <= ohm_next;
    end
  end

  assign key_evt_o       = evt_reg;
  assign digit_o         = evt_reg.key;
  assign ohm_state_o     = ohm_reg;
  assign ohm_upper_led_o = ohm_reg == TWO_STATE_UPPER;
  assign ohm_lower_led_o = ohm_reg == TWO_STATE_LOWER;

  //////////////////////////////////////////////////////////////////////////////
  // stepping keys

  logic up_stp;
  logic dn_stp;

  fpk_repeat #(
    .DELAY_CYC (RPT_DLY_CYC),
    .RATE_CYC  (RPT_CYC)
  ) u_rpt_up (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .press_i (prs[2]),
    .held_i  (lvl[2]),
    .step_o  (up_stp)
  );

  fpk_repeat #(
    .DELAY_CYC (RPT_DLY_CYC),
    .RATE_CYC  (RPT_CYC)
  ) u_rpt_dn (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .press_i (prs[3]),
    .held_i  (lvl[3]),
    .step_o  (dn_stp)
  );

  logic [LIST_W-1:0] pos_reg;
  wire [LIST_W-1:0]  last_pos = list_len_i - LIST_W'(1);
  wire               do_up    = up_stp && !dn_stp;
  wire               do_dn    = dn_stp && !up_stp;
  // lists wrap round at either end
  wire [LIST_W-1:0]  pos_next = do_up ? ((pos_reg >= last_pos) ? '0 : pos_reg + LIST_W'(1))
                              : do_dn ? ((pos_reg == '0) ? last_pos : pos_reg - LIST_W'(1))
                              : pos_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) pos_reg <= '0;
    else if (list_load_i) pos_reg <= '0;
    else pos_reg <= pos_next;
  end

  assign list_pos_o = pos_reg;
  assign step_up_o  = do_up;
  assign step_dn_o  = do_dn;

  //////////////////////////////////////////////////////////////////////////////
  // power-up message

  fpk_msg_e       msg_reg;
  fpk_pwrup_cmd_s cmd_reg;

  wire fpk_msg_e msg_pick = !mem_intact_i ? FPK_MSG_INITIALISED
                          : db_fault_i    ? FPK_MSG_RESET
                          : FPK_MSG_RESTORED;

  // decided once; later input changes do not alter it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      msg_reg <= FPK_MSG_NONE;
      cmd_reg <= '0;
    end else if (pwrup_done_i && msg_reg == FPK_MSG_NONE) begin
      msg_reg                       <= msg_pick;
      cmd_reg.load_default_settings <= msg_pick != FPK_MSG_RESTORED;
      cmd_reg.erase_history         <= msg_pick == FPK_MSG_INITIALISED;
      cmd_reg.erase_setups          <= msg_pick == FPK_MSG_INITIALISED;
    end else begin
      cmd_reg <= '0;
    end
  end

  assign msg_o       = msg_reg;
  assign pwrup_cmd_o = cmd_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  chk_shift_excl: assert property (@(posedge clk_i) disable iff (rst_i)
    !self_test_i |=> !(setup_on_reg && number_on_reg))
    else $error("both shift keys on outside self test");

  chk_shift_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    setup_prs |=> setup_on_reg != $past(setup_on_reg))
    else $error("set-up shift did not toggle");

  chk_two_state: assert property (@(posedge clk_i) disable iff (rst_i)
    ohm_hit && ohm_reg == TWO_STATE_LOWER |=> ohm_reg == TWO_STATE_OFF)
    else $error("two-state key did not return to off");

  chk_led_one: assert property (@(posedge clk_i) disable iff (rst_i)
    !(ohm_upper_led_o && ohm_lower_led_o))
    else $error("both state LEDs lit");

  chk_step_one: assert property (@(posedge clk_i) disable iff (rst_i)
    do_up && !list_load_i && pos_reg < last_pos |=> pos_reg == $past(pos_reg) + 1)
    else $error("step did not move one entry");

  chk_mode_map: assert property (@(posedge clk_i) disable iff (rst_i)
    any_main && setup_on_reg |=> key_evt_o.valid && key_evt_o.mode == FPK_MODE_SETUP)
    else $error("set-up mode event wrong");

  chk_msg_once: assert property (@(posedge clk_i) disable iff (rst_i)
    msg_o != FPK_MSG_NONE |=> msg_o == $past(msg_o))
    else $error("power-up message changed");

  chk_init_erase: assert property (@(posedge clk_i) disable iff (rst_i)
    pwrup_done_i && msg_reg == FPK_MSG_NONE && !mem_intact_i
      |=> pwrup_cmd_o.erase_history && msg_o == FPK_MSG_INITIALISED)
    else $error("initialise did not erase");

  chk_number_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    number_prs && !setup_prs |=> number_on_reg != $past(number_on_reg))
    else $error("number shift did not toggle");

  chk_step_back: assert property (@(posedge clk_i) disable iff (rst_i)
    do_dn && !list_load_i && pos_reg != '0 |=> pos_reg == $past(pos_reg) - LIST_W'(1))
    else $error("back step did not move one entry");

  // a step with the key already released would be a phantom repeat
  chk_step_held: assert property (@(posedge clk_i) disable iff (rst_i)
    up_stp |-> lvl[2])
    else $error("forward step without key held");

  chk_mode_normal: assert property (@(posedge clk_i) disable iff (rst_i)
    any_main && !setup_on_reg && !number_on_reg |=> key_evt_o.mode == FPK_MODE_NORMAL)
    else $error("normal mode event wrong");

  chk_mode_number: assert property (@(posedge clk_i) disable iff (rst_i)
    any_main && number_on_reg && !setup_on_reg
      |=> key_evt_o.mode == FPK_MODE_NUMBER && digit_o == $past(main_idx))
    else $error("number mode event wrong");

  chk_reset_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    pwrup_done_i && msg_reg == FPK_MSG_NONE && mem_intact_i && db_fault_i
      |=> msg_o == FPK_MSG_RESET && pwrup_cmd_o.load_default_settings
          && !pwrup_cmd_o.erase_history && !pwrup_cmd_o.erase_setups)
    else $error("settings fault handling wrong");

  chk_restore_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    pwrup_done_i && msg_reg == FPK_MSG_NONE && mem_intact_i && !db_fault_i
      |=> msg_o == FPK_MSG_RESTORED && pwrup_cmd_o == '0)
    else $error("restore touched memory");

  cov_setup_mode: cover property (@(posedge clk_i) disable iff (rst_i) mode_o == FPK_MODE_SETUP);
  cov_ohm_cycle: cover property (@(posedge clk_i) disable iff (rst_i)
    ohm_hit && ohm_reg == TWO_STATE_LOWER ##1 ohm_reg == TWO_STATE_OFF);
  cov_shift_both: cover property (@(posedge clk_i) disable iff (rst_i)
    self_test_i && setup_on_reg && number_on_reg);
  cov_auto_repeat: cover property (@(posedge clk_i) disable iff (rst_i)
    up_stp && !prs[2]);
  cov_msg_reset: cover property (@(posedge clk_i) disable iff (rst_i) msg_o == FPK_MSG_RESET);

endmodule : fpk_front_panel

// *** design/fpk_pkg.sv ***
package fpk_pkg;

  // key debounce / auto-repeat / flash timing, memory retention
  localparam int unsigned CLK_HZ           = 200_000_000;
  localparam int unsigned DEBOUNCE_MS      = 10;
  localparam int unsigned DEBOUNCE_CYC     = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned REPEAT_DELAY_MS  = 500;
  localparam int unsigned REPEAT_DELAY_CYC = CLK_HZ / 1000 * REPEAT_DELAY_MS;
  localparam int unsigned REPEAT_RATE_MS   = 100;
  localparam int unsigned REPEAT_RATE_CYC  = CLK_HZ / 1000 * REPEAT_RATE_MS;
  localparam int unsigned FLASH_MS         = 250;
  localparam int unsigned FLASH_CYC        = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned RETENTION_HOURS  = 100;

  localparam int unsigned NUM_MAIN_KEYS = 16;
  localparam int unsigned MAIN_IDX_W    = 4;
  localparam int unsigned LIST_W        = 8;

  typedef enum logic [1:0] {
    FPK_MODE_NORMAL,
    FPK_MODE_SETUP,
    FPK_MODE_NUMBER
  } fpk_mode_e;

  typedef enum logic [1:0] {
    FPK_MSG_NONE,
    FPK_MSG_RESTORED,
    FPK_MSG_RESET,
    FPK_MSG_INITIALISED
  } fpk_msg_e;

  // one decoded main-key event
  typedef struct packed {
    logic                  valid;
    fpk_mode_e             mode;
    logic [MAIN_IDX_W-1:0] key;
  } fpk_key_evt_s;

  // power-up housekeeping commands
  typedef struct packed {
    logic load_default_settings;
    logic erase_history;
    logic erase_setups;
  } fpk_pwrup_cmd_s;

  localparam logic [1:0] TWO_STATE_OFF   = 2'h0;
  localparam logic [1:0] TWO_STATE_UPPER = 2'h1;
  localparam logic [1:0] TWO_STATE_LOWER = 2'h2;

endpackage : fpk_pkg

// *** design/fpk_debounce.sv ***
`timescale 1ns/10ps
module fpk_debounce
  import fpk_pkg::*;
#(
  parameter int unsigned WIDTH      = 4,
  parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
) (
  input  wire logic             clk_i,    // system clock
  input  wire logic             rst_i,    // async reset, active high
  input  wire logic [WIDTH-1:0] raw_i,    // raw key contacts
  output logic      [WIDTH-1:0] level_o,  // debounced level
  output logic      [WIDTH-1:0] press_o   // one-cycle press pulse
);

  localparam int unsigned CW = $clog2(STABLE_CYC + 1);

  for (genvar g = 0; g < WIDTH; g++) begin : g_key
    logic          s1_reg;
    logic          s2_reg;
    logic          lvl_reg;
    logic          pls_reg;
    logic [CW-1:0] cnt_reg;
    wire           differs = s2_reg != lvl_reg;
    wire           settled = cnt_reg == CW'(STABLE_CYC - 1);

    // only a level held for the whole window is taken, so bounce gives one press
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        s1_reg  <= 1'b0;
        s2_reg  <= 1'b0;
        lvl_reg <= 1'b0;
        pls_reg <= 1'b0;
        cnt_reg <= '0;
      end else begin
        s1_reg  <= raw_i[g];
        s2_reg  <= s1_reg;
        pls_reg <= differs && settled && s2_reg;
        if (!differs) cnt_reg <= '0;
        else if (settled) begin
          cnt_reg <= '0;
          lvl_reg <= s2_reg;
        end else cnt_reg <= cnt_reg + CW'(1);
      end
    end
    assign level_o[g] = lvl_reg;
    assign press_o[g] = pls_reg;
  end

endmodule : fpk_debounce

// *** design/fpk_repeat.sv ***
`timescale 1ns/10ps
module fpk_repeat
  import fpk_pkg::*;
#(
  parameter int unsigned DELAY_CYC = REPEAT_DELAY_CYC,
  parameter int unsigned RATE_CYC  = REPEAT_RATE_CYC
) (
  input  wire logic clk_i,    // system clock
  input  wire logic rst_i,    // async reset, active high
  input  wire logic press_i,  // debounced press pulse
  input  wire logic held_i,   // debounced level
  output logic      step_o    // one step pulse
);

  localparam int unsigned CW = $clog2(DELAY_CYC + 1);

  logic [CW-1:0] cnt_reg;
  logic          rpt_reg;
  wire           lim_hit = rpt_reg ? (cnt_reg == CW'(RATE_CYC - 1))
                                   : (cnt_reg == CW'(DELAY_CYC - 1));
  wire           tick    = held_i && !press_i && lim_hit;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      rpt_reg <= 1'b0;
    end else if (!held_i || press_i) begin
      cnt_reg <= '0;
      rpt_reg <= 1'b0;
    end else if (lim_hit) begin
      cnt_reg <= '0;
      rpt_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  // first step on the press, then auto-repeat while held
  assign step_o = press_i || tick;

endmodule : fpk_repeat

// *** test/fpk_operator.sv ***
`timescale 1ns/10ps
module fpk_operator
  import fpk_pkg::*;
#(
  parameter int unsigned NK = 20
) (
  input  wire logic          clk_i,  // system clock
  output logic      [NK-1:0] keys_o  // raw contacts, high while pressed
);
  initial keys_o = '0;

  // a real finger chatters: one short spike ahead of the steady press
  task automatic tap(input int idx, input int hold, input bit bounce);
    @(negedge clk_i);
    if (bounce) begin
      keys_o[idx] = 1'b1;
      @(negedge clk_i);
      keys_o[idx] = 1'b0;
      @(negedge clk_i);
    end
    keys_o[idx] = 1'b1;
    repeat (hold) @(negedge clk_i);
    keys_o[idx] = 1'b0;
  endtask : tap
endmodule : fpk_operator

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top
  import fpk_pkg::*;
;
  localparam int DEB = 4;
  localparam int DLY = 20;
  localparam int RPT = 8;
  localparam int FLS = 4;
  localparam int SETTLE = DEB + 8;

  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [19:0]       keys;
  logic              self_test = 1'b0;
  logic              list_load = 1'b0;
  logic [LIST_W-1:0] list_len = 8'h05;
  logic              mem_ok = 1'b1;
  logic              db_bad = 1'b0;
  logic              pw_done = 1'b0;
  logic              setup_led, number_led, ohm_up, ohm_lo, st_up, st_dn;
  fpk_mode_e         mode;
  fpk_key_evt_s      evt, last_evt;
  logic [3:0]        digit, last_dig;
  logic              st_low_q = 1'b1;
  logic [1:0]        ohm_st, hi, lo;
  logic [7:0]        pos;
  fpk_msg_e          msg;
  fpk_pwrup_cmd_s    cmd;
  int                n_errors = 0;
  int                checks_done = 0;
  int                n_evt = 0, n_up = 0, n_dn = 0, n_both = 0;
  int                e0, u0, steps;

  always #2.5 clk_i = ~clk_i;

  fpk_operator op (.clk_i(clk_i), .keys_o(keys));

  fpk_front_panel #(.DEB_CYC(DEB), .RPT_DLY_CYC(DLY), .RPT_CYC(RPT), .FLS_CYC(FLS)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .setup_key_i(keys[0]), .number_key_i(keys[1]),
    .step_up_key_i(keys[2]), .step_dn_key_i(keys[3]), .main_keys_i(keys[19:4]),
    .self_test_i(self_test), .list_len_i(list_len), .list_load_i(list_load),
    .mem_intact_i(mem_ok), .db_fault_i(db_bad), .pwrup_done_i(pw_done),
    .setup_led_o(setup_led), .number_led_o(number_led), .mode_o(mode), .key_evt_o(evt),
    .digit_o(digit), .ohm_upper_led_o(ohm_up), .ohm_lower_led_o(ohm_lo),
    .ohm_state_o(ohm_st), .list_pos_o(pos), .step_up_o(st_up), .step_dn_o(st_dn),
    .msg_o(msg), .pwrup_cmd_o(cmd));

  //////////////////////////////////////////////////////////////////////////////
  // event pulses last one cycle, so they are counted here rather than polled
  always @(posedge clk_i) begin
    if (evt.valid === 1'b1) begin
      n_evt++;
      last_evt = evt;
      last_dig = digit;
    end
    if (st_up === 1'b1) n_up++;
    if (st_dn === 1'b1) n_dn++;
  end

  // one cycle of grace after self test ends, while the design drops a shift
  always @(negedge clk_i) begin
    if (st_low_q && self_test === 1'b0 && setup_led === 1'b1 && number_led === 1'b1) n_both++;
    st_low_q = self_test === 1'b0;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("[ERR] t=%0t watchdog expired", $time);
    stop_test();
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // press with chatter, then wait out the release debounce as well
  task automatic key(input int idx);
    op.tap(idx, DEB + 4, 1'b1);
    repeat (SETTLE) @(negedge clk_i);
  endtask : key

  task automatic led_scan;
    hi = 2'h0;
    lo = 2'h0;
    repeat (4 * FLS) begin
      @(negedge clk_i);
      hi |= {setup_led, number_led};
      lo |= ~{setup_led, number_led};
    end
  endtask : led_scan

  task automatic power_up(input logic ok, input logic bad, input logic [1:0] em,
                          input logic [2:0] ec);
    int n;
    rst_i = 1'b1;
    pw_done = 1'b0;
    mem_ok = ok;
    db_bad = bad;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    chk({14'h0, msg}, 16'h0000);
    pw_done = 1'b1;
    n = 0;
    while (msg === FPK_MSG_NONE && n < 6) begin
      @(negedge clk_i);
      n++;
    end
    if (msg === FPK_MSG_NONE) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, msg, em);
      stop_test();
    end else begin
      chk({14'h0, msg}, {14'h0, em});
      chk({13'h0, cmd}, {13'h0, ec});
      @(negedge clk_i);
      chk({13'h0, cmd}, 16'h0000);
      // late changes of the health inputs must not bring a second message
      mem_ok = ~ok;
      db_bad = ~bad;
      repeat (4) @(negedge clk_i);
      chk({14'h0, msg}, {14'h0, em});
    end
  endtask : power_up

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    power_up(1'b1, 1'b1, 2'h2, 3'h4);
    power_up(1'b0, 1'b1, 2'h3, 3'h7);
    power_up(1'b0, 1'b0, 2'h3, 3'h7);
    power_up(1'b1, 1'b0, 2'h1, 3'h0);
    // normal, then set-up, then number entry; number shift also drops set-up
    for (int m = 0; m < 3; m++) begin
      if (m == 1) key(0);
      if (m == 2) key(1);
      chk({14'h0, mode}, m[15:0]);
      led_scan();
      if (m == 0) chk({12'h0, hi, lo}, 16'h0003);
      if (m == 1) chk({12'h0, hi, lo}, 16'h000B);
      if (m == 2) chk({12'h0, hi, lo}, 16'h0007);
      e0 = n_evt;
      key(5 + m * 4);
      chk(16'(n_evt - e0), 16'h0001);
      chk({9'h0, last_evt}, {9'h0, 1'b1, m[1:0], 4'(1 + m * 4)});
      if (m == 2) chk({12'h0, last_dig}, 16'(1 + m * 4));
    end
    key(1);
    chk({14'h0, mode}, 16'h0000);
    led_scan();
    chk({12'h0, hi, lo}, 16'h0003);
    // two-state key cycles upper, lower, off
    for (int i = 1; i < 4; i++) begin
      key(4);
      chk({14'h0, ohm_st}, 16'(i % 3));
      chk({14'h0, ohm_up, ohm_lo}, {14'h0, (i % 3) == 1, (i % 3) == 2});
    end
    // single steps, including wrap below the first entry
    @(negedge clk_i);
    list_load = 1'b1;
    @(negedge clk_i);
    list_load = 1'b0;
    @(negedge clk_i);
    chk({8'h0, pos}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      e0 = n_up + n_dn;
      key((i == 1 || i == 2) ? 3 : 2);
      chk(16'(n_up + n_dn - e0), 16'h0001);
      chk({8'h0, pos}, (i == 0) ? 16'h1 : (i == 2) ? 16'h4 : 16'h0);
    end
    // held key: steps keep coming, and stop with the release
    u0 = n_up;
    op.tap(2, DLY + 3 * RPT + DEB, 1'b0);
    repeat (SETTLE) @(negedge clk_i);
    steps = n_up - u0;
    chk({15'h0, steps >= 3 && steps <= 6}, 16'h0001);
    chk({8'h0, pos}, 16'(steps % 5));
    repeat (3 * RPT) @(negedge clk_i);
    chk(16'(n_up - u0), 16'(steps));
    // self test lets both shifts stand; leaving it must drop the number shift
    self_test = 1'b1;
    key(0);
    key(1);
    chk({14'h0, mode}, 16'h0001);
    led_scan();
    chk({12'h0, hi, lo}, 16'h000F);
    self_test = 1'b0;
    repeat (2) @(negedge clk_i);
    chk({14'h0, mode}, 16'h0001);
    led_scan();
    chk({12'h0, hi, lo}, 16'h000B);
    key(0);
    chk({14'h0, mode}, 16'h0000);
    chk(16'(n_both), 16'h0000);
    stop_test();
  end
endmodule : tb_top
